/* sim/dxc_core_monitor.sv */
// Concurrent checks on the extender control ports.
`timescale 1ns/1ps
module dxc_core_monitor #(parameter TIMEOUT_CYC = 50) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_mode_shutdown,
  input wire i_supply_lockout,
  input wire i_over_temp,
  input wire i_local_clock,
  input wire o_local_clock_oe,
  input wire o_local_data_oe,
  input wire o_clock_pair_high,
  input wire o_clock_pair_low,
  input wire o_clock_pair_oe,
  input wire o_data_pair_oe,
  input wire o_rx_resistance_on,
  input wire o_master_mode
);
  reg [15:0] dom_ff;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Length of the present dominant stretch, since the timer has no port of its own.
  always @(posedge i_sys_clk) begin
    dom_ff <= (i_rst | !o_clock_pair_oe) ? 16'h0000 : dom_ff + 16'h0001;
  end
  a_shutdown_quiet: assert property (i_mode_shutdown[*4] |->
    !o_clock_pair_oe && !o_data_pair_oe && !o_rx_resistance_on) else $error("shutdown drive");
  a_lockout_quiet: assert property (i_supply_lockout[*4] |-> !o_local_clock_oe
    && !o_local_data_oe && !o_clock_pair_oe && !o_data_pair_oe) else $error("lockout drive");
  a_hot_quiet: assert property (i_over_temp[*4] |->
    !o_clock_pair_oe && !o_data_pair_oe) else $error("overtemp drive");
  a_high_recessive: assert property (i_local_clock[*4] |-> !o_clock_pair_oe)
    else $error("clock pair dominant while line high");
  a_pair_levels: assert property (o_clock_pair_high == o_clock_pair_oe && !o_clock_pair_low)
    else $error("clock pair levels");
  a_timeout_cap: assert property (dom_ff <= TIMEOUT_CYC + 2) else $error("dominant too long");
  a_clock_one_way: assert property (o_master_mode ? !o_local_clock_oe : !o_clock_pair_oe)
    else $error("clock direction");
  a_data_one_way: assert property (!(o_data_pair_oe && o_local_data_oe))
    else $error("data both ways");
  c_timed_out: cover property (o_clock_pair_oe ##1 !o_clock_pair_oe && !i_local_clock);
  c_data_in: cover property (o_local_data_oe);
  c_clock_in: cover property (o_local_clock_oe);
endmodule
bind dxc_core dxc_core_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon (.*);

/* sim/dxc_peer.sv */
// Far side model: the peer transceiver on both pairs.
`timescale 1ns/1ps
module dxc_peer (
  input wire i_frame,
  input wire i_data_pull,
  input wire i_clock_pair_oe,
  input wire i_data_pair_oe,
  output wire o_clock_pair_dominant,
  output wire o_data_pair_dominant
);
  reg link_ff;
  // The link clock runs only inside a frame and rests recessive between frames.
  initial begin
    link_ff = 1'b0;
    #137;
    forever #400 link_ff = i_frame ? ~link_ff : 1'b0;
  end
  // Each receiver also hears its own driver, as on a real shared pair.
  assign o_clock_pair_dominant = link_ff | i_clock_pair_oe;
  assign o_data_pair_dominant = i_data_pull | i_data_pair_oe;
endmodule

/* sim/test_dxc_core.sv */
// Bench for the extender control logic against a peer model.
`timescale 1ns/1ps
module test_dxc_core;
  reg i_sys_clk, i_rst, i_mode_shutdown, i_mode_master, i_supply_lockout, i_over_temp;
  reg pull_clk, pull_dat, frame, peer_dat;
  integer fails, total_checks, ticks, n;
  wire o_local_clock_oe, o_local_data_oe, o_clock_pair_high, o_clock_pair_low, o_clock_pair_oe;
  wire o_data_pair_high, o_data_pair_low, o_data_pair_oe, o_rx_resistance_on, o_master_mode;
  wire i_clock_pair_dominant, i_data_pair_dominant;
  // Open-drain local lines are low when the bench or the design pulls.
  wire i_local_clock = ~(pull_clk | o_local_clock_oe);
  wire i_local_data = ~(pull_dat | o_local_data_oe);
  dxc_core #(.TIMEOUT_CYC(50), .RXEN_CYC(4), .SETTLE_CYC(3)) uut (.*);
  dxc_peer peer (.i_frame(frame), .i_data_pull(peer_dat), .i_clock_pair_oe(o_clock_pair_oe),
    .i_data_pair_oe(o_data_pair_oe), .o_clock_pair_dominant(i_clock_pair_dominant),
    .o_data_pair_dominant(i_data_pair_dominant));
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] nm, input e, input g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("ERROR %0s expected %b seen %b", nm, e, g);
      end
    end
  endtask
  // Outputs answer three edges after an input change, four when a fall must
  // first rearm the timeout; the 1 ns lets them land.
  task cyc(input integer k);
    begin
      repeat (k) @(posedge i_sys_clk);
      #1;
    end
  endtask
  task t_start;
    begin
      cyc(10);
      chk("cpair", 1'b0, o_clock_pair_oe);
      chk("rxres", 1'b1, o_rx_resistance_on);
      @(posedge i_sys_clk) pull_clk <= 1'b0;
      cyc(5);
      @(posedge i_sys_clk) pull_clk <= 1'b1;
      cyc(4);
      chk("cpair", 1'b1, o_clock_pair_oe);
      chk("chigh", 1'b1, o_clock_pair_high);
      @(posedge i_sys_clk) pull_clk <= 1'b0;
      cyc(3);
      chk("cpair", 1'b0, o_clock_pair_oe);
    end
  endtask
  task t_timeout;
    begin
      @(posedge i_sys_clk) pull_clk <= 1'b1;
      cyc(40);
      chk("cpair", 1'b1, o_clock_pair_oe);
      cyc(18);
      chk("cpair", 1'b0, o_clock_pair_oe);
      @(posedge i_sys_clk) pull_clk <= 1'b0;
      cyc(2);
      @(posedge i_sys_clk) pull_clk <= 1'b1;
      cyc(4);
      chk("cpair", 1'b1, o_clock_pair_oe);
    end
  endtask
  task t_data;
    begin
      @(posedge i_sys_clk) peer_dat <= 1'b1;
      cyc(3);
      chk("ldata", 1'b1, o_local_data_oe);
      chk("dpair", 1'b0, o_data_pair_oe);
      @(posedge i_sys_clk) peer_dat <= 1'b0;
      cyc(3);
      chk("ldata", 1'b0, o_local_data_oe);
      cyc(6);
      @(posedge i_sys_clk) pull_dat <= 1'b1;
      cyc(3);
      chk("dpair", 1'b1, o_data_pair_oe);
      chk("ldata", 1'b0, o_local_data_oe);
      @(posedge i_sys_clk) pull_dat <= 1'b0;
      cyc(3);
      chk("dpair", 1'b0, o_data_pair_oe);
    end
  endtask
  task t_fault;
    begin
      @(posedge i_sys_clk) i_over_temp <= 1'b1;
      cyc(3);
      chk("cpair", 1'b0, o_clock_pair_oe);
      @(posedge i_sys_clk) i_over_temp <= 1'b0;
      cyc(8);
      chk("rxres", 1'b1, o_rx_resistance_on);
      @(posedge i_sys_clk) i_supply_lockout <= 1'b1;
      cyc(3);
      chk("rxres", 1'b0, o_rx_resistance_on);
      @(posedge i_sys_clk) i_supply_lockout <= 1'b0;
      cyc(8);
      chk("rxres", 1'b1, o_rx_resistance_on);
      @(posedge i_sys_clk) i_mode_shutdown <= 1'b1;
      i_mode_master <= 1'b0;
      pull_clk <= 1'b0;
      cyc(3);
      chk("rxres", 1'b0, o_rx_resistance_on);
    end
  endtask
  task t_slave;
    begin
      @(posedge i_sys_clk) i_mode_shutdown <= 1'b0;
      cyc(10);
      frame <= 1'b1;
      n = 0;
      while (!i_clock_pair_dominant && n < 20) begin
        @(posedge i_sys_clk);
        n = n + 1;
      end
      cyc(3);
      chk("lclock", 1'b1, o_local_clock_oe);
      chk("cpair", 1'b0, o_clock_pair_oe);
      frame <= 1'b0;
    end
  endtask
  // Free-running clock and a hang limit of 3000 cycles.
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    ticks = ticks + 1;
    if (ticks == 3000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // Local clock starts low so the pair must stay quiet until its first fall.
  initial begin
    {fails, total_checks, ticks} = 0;
    // The mode input is driven by the bench itself, high until the shutdown step of t_fault, not by the master's own output.
    {i_rst, i_mode_master, pull_clk} = 3'h7;
    {i_mode_shutdown, i_supply_lockout, i_over_temp, pull_dat, frame, peer_dat} = 6'h00;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_start;
    t_timeout;
    t_data;
    t_fault;
    t_slave;
    test_done;
  end
endmodule

/* src/dxc_core.v */
// Control logic of a two-channel differential serial bus extender.
// Notes on behaviour
// (RULE1) Master transceiver gets mode input above 2.5V.
// (RULE2) Target transceivers hold mode input mid-range.
// (RULE3) Floating mode input enables slave mode.
// (RULE4) Master drives mode pin low until charged.
// (RULE5) Never tie master mode pin to supply.
// (RULE6) Low local line drives pair dominant.
// (RULE7) High local line leaves pair recessive.
// (RULE8) Shutdown or lockout tristates drivers, disconnects resistance.
// (RULE9) Dominant driving limited to about 1.5ms.
// (RULE10) Local line high clears the timeout.
// (RULE11) Overtemperature forces shutdown and tristates drivers.
// (RULE12) Outputs stay off until supply is sufficient.
// (RULE13) Activate only when mode input enables.
// (RULE14) Receivers enable after short delay.
// (RULE15) Drivers start timed out until first falling edge.
// (RULE16) Undervoltage shuts down immediately.
// (RULE17) No ordinary bus transceivers on the pairs.
// (RULE18) Clock channel is one-way by mode.
// (RULE19) First dominant side sets data direction.
// (RULE20) After release, wait for pair to settle.
// (RULE21) Timeout counts on the internal clock.
// (RULE22) Analog decisions arrive as digital inputs.
`timescale 1ns/1ps
`include "dxc_defs.vh"
module dxc_core #(
  parameter TIMEOUT_CYC = `DXC_TIMEOUT_CYC,
  parameter RXEN_CYC = `DXC_RXEN_CYC,
  parameter SETTLE_CYC = `DXC_SETTLE_CYC
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_mode_shutdown,
  input wire i_mode_master,
  input wire i_supply_lockout,
  input wire i_over_temp,
  input wire i_local_clock,
  input wire i_local_data,
  input wire i_clock_pair_dominant,
  input wire i_data_pair_dominant,
  output reg o_local_clock_oe,
  output reg o_local_data_oe,
  output reg o_clock_pair_high,
  output reg o_clock_pair_low,
  output reg o_clock_pair_oe,
  output reg o_data_pair_high,
  output reg o_data_pair_low,
  output reg o_data_pair_oe,
  output reg o_rx_resistance_on,
  output reg o_master_mode
);
  // Sync order: shutdown, master, lockout, overtemp, lclk, ldata, pclk, pdata.
  wire [7:0] syn;
  wire active;
  wire scl_low;
  wire sda_low;
  wire pclk_dom;
  wire pdat_dom;
  wire clk_allow;
  wire dat_allow;
  reg [15:0] rxen_cnt_ff;
  reg rx_on_ff;
  reg [1:0] dir_ff;
  reg [1:0] nxt_dir;
  reg [15:0] settle_cnt_ff;
  reg mode_ff;
  reg act_ff;
  reg nxt_drv_clk;
  reg nxt_drv_dat;
  reg nxt_lclk;
  reg nxt_ldat;

  // Pins and comparator decisions are asynchronous, so all pass two flops.
  dxc_sync #(.W(8), .INIT(8'h3D)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_mode_shutdown, i_mode_master, i_supply_lockout, i_over_temp,
              i_local_clock, i_local_data, i_clock_pair_dominant,
              i_data_pair_dominant}),
    .o_sync(syn)
  ); // (RULE22)

  // Floating mode input reads as not-shutdown, not-master: slave mode.
  assign active = ~syn[7] & ~syn[5] & ~syn[4]; // (RULE3) (RULE8) (RULE11) (RULE13)
  assign scl_low = ~syn[3];
  assign sda_low = ~syn[2];
  assign pclk_dom = syn[1];
  assign pdat_dom = syn[0];

  // Timers run from the one free-running clock, and reset with the chip.
  dxc_timeout #(.CNT(TIMEOUT_CYC)) u_to_clk (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_active(active),
    .i_line_low(scl_low),
    .o_allow(clk_allow)
  ); // (RULE21)

  dxc_timeout #(.CNT(TIMEOUT_CYC)) u_to_dat (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_active(active),
    .i_line_low(sda_low),
    .o_allow(dat_allow)
  );

  // Mode is latched while inactive so it cannot flip mid-traffic.
  // The first active cycle also captures it, because the synchronised mode
  // level only becomes valid in the same cycle that activation is seen.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      mode_ff <= 1'b0;
      act_ff <= 1'b0;
    end else begin
      act_ff <= active;
      if (!active || !act_ff) begin
        mode_ff <= syn[6];
      end
    end
  end

  // Receivers open only after the enable delay from activation.
  always @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      rxen_cnt_ff <= 16'h0000;
      rx_on_ff <= 1'b0;
    end else if (!rx_on_ff) begin
      if (rxen_cnt_ff >= RXEN_CYC[15:0] - 16'h0001) begin
        rx_on_ff <= 1'b1; // (RULE14)
      end else begin
        rxen_cnt_ff <= rxen_cnt_ff + 16'h0001;
      end
    end
  end

  // Data direction arbiter: first dominant side wins, then settle wait.
  always @* begin
    nxt_dir = dir_ff;
    case (dir_ff)
      `DXC_DIR_IDLE: begin
        if (sda_low && !pdat_dom) begin
          nxt_dir = `DXC_DIR_L2P; // (RULE19)
        end else if (pdat_dom && !sda_low && rx_on_ff) begin
          nxt_dir = `DXC_DIR_P2L; // (RULE19)
        end
      end
      `DXC_DIR_L2P: begin
        if (!sda_low) begin
          nxt_dir = `DXC_DIR_SETTLE; // (RULE20)
        end
      end
      `DXC_DIR_P2L: begin
        if (!pdat_dom) begin
          nxt_dir = `DXC_DIR_SETTLE; // (RULE20)
        end
      end
      `DXC_DIR_SETTLE: begin
        if (settle_cnt_ff >= SETTLE_CYC[15:0] - 16'h0001 && !pdat_dom) begin
          nxt_dir = `DXC_DIR_IDLE; // (RULE20)
        end
      end
      default: begin
        nxt_dir = `DXC_DIR_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      dir_ff <= `DXC_DIR_IDLE;
      settle_cnt_ff <= 16'h0000;
    end else begin
      dir_ff <= nxt_dir;
      if (dir_ff != `DXC_DIR_SETTLE || pdat_dom) begin
        settle_cnt_ff <= 16'h0000;
      end else if (settle_cnt_ff != 16'hFFFF) begin
        settle_cnt_ff <= settle_cnt_ff + 16'h0001;
      end
    end
  end

  // Next driver states; clock channel direction follows the mode only.
  always @* begin
    nxt_drv_clk = mode_ff & scl_low & clk_allow; // (RULE6) (RULE7) (RULE9) (RULE18)
    nxt_lclk = ~mode_ff & rx_on_ff & pclk_dom; // (RULE18)
    nxt_drv_dat = (nxt_dir == `DXC_DIR_L2P) & sda_low & dat_allow; // (RULE6) (RULE7)
    nxt_ldat = rx_on_ff & (nxt_dir == `DXC_DIR_P2L) & pdat_dom; // (RULE19)
  end

  // Registered outputs; inactive forces every driver off at once.
  always @(posedge i_sys_clk) begin
    if (i_rst || !active) begin
      o_local_clock_oe <= 1'b0; // (RULE12) (RULE16)
      o_local_data_oe <= 1'b0;
      o_clock_pair_high <= 1'b0;
      o_clock_pair_low <= 1'b0;
      o_clock_pair_oe <= 1'b0; // (RULE8) (RULE11)
      o_data_pair_high <= 1'b0;
      o_data_pair_low <= 1'b0;
      o_data_pair_oe <= 1'b0;
      o_rx_resistance_on <= 1'b0; // (RULE8)
      o_master_mode <= 1'b0;
    end else begin
      o_local_clock_oe <= nxt_lclk;
      o_local_data_oe <= nxt_ldat;
      o_clock_pair_high <= nxt_drv_clk;
      o_clock_pair_low <= 1'b0;
      o_clock_pair_oe <= nxt_drv_clk;
      o_data_pair_high <= nxt_drv_dat;
      o_data_pair_low <= 1'b0;
      o_data_pair_oe <= nxt_drv_dat;
      o_rx_resistance_on <= 1'b1;
      o_master_mode <= mode_ff;
    end
  end
endmodule

/* src/dxc_defs.vh */
// Constants shared by the differential bus extender control logic.
`ifndef DXC_DEFS_VH
`define DXC_DEFS_VH
`define DXC_CLK_HZ 10000000
`define DXC_TIMEOUT_US 1500
`define DXC_TIMEOUT_CYC ((`DXC_TIMEOUT_US * (`DXC_CLK_HZ / 1000000)))
`define DXC_RXEN_US 2
`define DXC_RXEN_CYC ((`DXC_RXEN_US * (`DXC_CLK_HZ / 1000000)))
`define DXC_SETTLE_US 1
`define DXC_SETTLE_CYC ((`DXC_SETTLE_US * (`DXC_CLK_HZ / 1000000)))
`define DXC_DIR_IDLE 2'h0
`define DXC_DIR_L2P 2'h1
`define DXC_DIR_P2L 2'h2
`define DXC_DIR_SETTLE 2'h3
`endif

/* src/dxc_sync.v */
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module dxc_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // The first stage feeds only the second stage.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

/* src/dxc_timeout.v */
// Dominant timeout timer for one channel.
`timescale 1ns/1ps
module dxc_timeout #(
  parameter CNT = 15000
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_active,
  input wire i_line_low,
  output wire o_allow
);
  reg [23:0] cnt_ff;
  reg expired_ff;
  reg prev_low_ff;
  wire fall;

  assign fall = i_line_low & ~prev_low_ff;

  // Starts expired; a falling edge rearms, a high line clears the count.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_ff <= 24'h000000;
      expired_ff <= 1'b1;
      prev_low_ff <= 1'b1;
    end else if (!i_active) begin
      cnt_ff <= 24'h000000;
      expired_ff <= 1'b1; // (RULE15)
      prev_low_ff <= 1'b1;
    end else begin
      prev_low_ff <= i_line_low;
      if (!i_line_low) begin
        cnt_ff <= 24'h000000; // (RULE10)
      end else if (fall) begin
        cnt_ff <= 24'h000001;
        expired_ff <= 1'b0; // (RULE15)
      end else if (!expired_ff) begin
        if (cnt_ff >= CNT[23:0] - 24'h000001) begin
          expired_ff <= 1'b1; // (RULE9)
        end else begin
          cnt_ff <= cnt_ff + 24'h000001;
        end
      end
    end
  end

  assign o_allow = ~expired_ff;
endmodule
